//--- dmc_pkg.sv
// Shared constants and types for the dual converter mode control block.
// Assumes byte addressing on a 32-bit Avalon-MM slave with 8-bit registers.
package dmc_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [4:0] OFS_MODE = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h08;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h0C;
	localparam logic [4:0] OFS_CONFIG = 5'h10;

	// Mode control register fields.
	localparam int PRI_EN_BIT = 5;
	localparam int AUX_EN_BIT = 4;
	localparam int FIELD_LSB = 0;
	localparam int FIELD_W = 3;

	// Converter status register fields.
	localparam int ST_PRI_DONE = 0;
	localparam int ST_AUX_DONE = 1;
	localparam int ST_CAL_DONE = 2;
	localparam int ST_PRI_ERR = 3;
	localparam int ST_AUX_ERR = 4;

	// Interrupt status and mask fields.
	localparam int IRQ_W = 3;
	localparam int IRQ_PRI_DONE = 0;
	localparam int IRQ_AUX_DONE = 1;
	localparam int IRQ_OP_FINISH = 2;

	// Converter configuration register fields.
	localparam int CFG_PRI_REF = 0;
	localparam int CFG_AUX_REF = 1;
	localparam int CFG_PRI_CH_LSB = 2;
	localparam int CFG_AUX_CH_LSB = 4;
	localparam int CFG_W = 6;

	typedef enum logic [2:0] {
		OP_POWER_DOWN = 3'h0,
		OP_IDLE = 3'h1,
		OP_SINGLE = 3'h2,
		OP_CONTINUOUS = 3'h3,
		OP_INT_ZERO = 3'h4,
		OP_INT_FULL = 3'h5,
		OP_SYS_ZERO = 3'h6,
		OP_SYS_FULL = 3'h7
	} dmc_op_e;

	// Values after reset.
	localparam logic [1:0] ENABLE_RESET = 2'h0;
	localparam dmc_op_e FIELD_RESET = OP_POWER_DOWN;
	localparam logic [CFG_W-1:0] CONFIG_RESET = 6'h00;
	localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

	function automatic logic op_is_cal(input dmc_op_e op);
		return op inside {OP_INT_ZERO, OP_INT_FULL, OP_SYS_ZERO, OP_SYS_FULL};
	endfunction

	function automatic logic op_is_one_shot(input dmc_op_e op);
		return (op == OP_SINGLE) || op_is_cal(op);
	endfunction

endpackage

//--- dmc_sticky_flag.sv
// One sticky flag: a set in the same cycle as a clear wins.
// Assumes set and clear come from logic on ref_clk.
module dmc_sticky_flag (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Control.
	input wire logic set,
	input wire logic clear,
	// State.
	output logic flag
);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end

endmodule

//--- dmc_conv_ctrl.sv
// Control of one converter: decodes the shared operation for this converter,
// keeps its done and error flags and its pending one-shot operation.
// Assumes the converter pulses done_in for one cycle per finished result.
module dmc_conv_ctrl (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// From the mode control register.
	input wire logic enable,
	input wire dmc_pkg::dmc_op_e op,
	input wire logic field_write,
	input wire logic arm,
	input wire logic flag_clear,
	// From the converter.
	input wire logic done_in,
	input wire logic err_in,
	// To the converter.
	output logic run,
	output logic [2:0] conv_op,
	output logic conv_reset,
	output logic idle_hold,
	output logic short_inputs,
	output logic ref_apply,
	output logic result_we,
	output logic coef_we,
	// State.
	output logic done_flag,
	output logic err_flag,
	output logic pending,
	output logic done_evt
);

	logic active;

	assign active = enable && (op != dmc_pkg::OP_POWER_DOWN);
	// A converter holding an unread result is barred from producing another.
	assign done_evt = done_in && active && !done_flag;
	assign result_we = !done_flag;

	dmc_sticky_flag u_done (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.set(done_evt),
		.clear(flag_clear),
		.flag(done_flag)
	);

	dmc_sticky_flag u_err (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.set(done_evt && err_in),
		.clear(field_write),
		.flag(err_flag)
	);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pending <= 1'b0;
		end else if (arm) begin
			pending <= 1'b1;
		end else if (done_evt || !enable) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			run <= 1'b0;
			conv_op <= dmc_pkg::OP_POWER_DOWN;
			conv_reset <= 1'b0;
			idle_hold <= 1'b0;
			short_inputs <= 1'b0;
			ref_apply <= 1'b0;
			coef_we <= 1'b0;
		end else begin
			run <= active;
			conv_op <= active ? op : dmc_pkg::OP_POWER_DOWN;
			conv_reset <= field_write;
			idle_hold <= active && (op == dmc_pkg::OP_IDLE);
			short_inputs <= active && (op == dmc_pkg::OP_INT_ZERO);
			ref_apply <= active && (op == dmc_pkg::OP_INT_FULL);
			coef_we <= done_evt && dmc_pkg::op_is_cal(op) && !err_in;
		end
	end

endmodule

//--- dmc_top.sv
// Mode control for a primary and an auxiliary sigma-delta converter, with an
// Avalon-MM register slave and one level interrupt.
// Assumes converters, filters and multiplexers run on ref_clk.
//
// Functional notes
// - Mode bits 7, 6, 3 reserved, read zero.
// - Primary enable set runs selected operation.
// - Primary enable clear powers primary down.
// - Auxiliary enable set runs selected operation.
// - Auxiliary enable clear powers auxiliary down.
// - Field 000 is power-down, reset value.
// - Field 001 idle holds filter, modulator reset.
// - Field 010 performs exactly one conversion.
// - Single conversion end returns field to 000.
// - Field 011 converts continuously at decimated rate.
// - Field 100 internal zero-scale, inputs shorted.
// - Field 101 internal full-scale with selected reference.
// - Field 110 system zero-scale on selected channels.
// - Field 111 system full-scale on selected channels.
// - Any field write resets both converters.
// - Calibration clears flags, ends writing coefficients, 000.
// - Done flag set on completion, blocks results.
module dmc_top (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Avalon-MM slave.
	input wire logic [dmc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [dmc_pkg::DATA_W-1:0] avs_writedata,
	output logic [dmc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt.
	output logic irq,
	// Converter control, index 0 primary, index 1 auxiliary.
	output logic [1:0] conv_run,
	output logic [1:0][2:0] conv_op,
	output logic [1:0] conv_reset,
	output logic [1:0] conv_idle_hold,
	output logic [1:0] conv_short_inputs,
	output logic [1:0] conv_ref_apply,
	output logic [1:0] conv_result_we,
	output logic [1:0] conv_coef_we,
	// Input selection.
	output logic primary_reference_select,
	output logic auxiliary_reference_select,
	output logic [1:0] primary_channel_select,
	output logic [1:0] auxiliary_channel_select,
	// Converter completion.
	input wire logic [1:0] conv_done,
	input wire logic [1:0] conv_err
);

	logic ack;
	logic req;
	logic wr_fire;
	logic lane0;
	logic mode_wr;
	logic status_wr;
	logic irq_status_wr;
	logic [1:0] enable;
	dmc_pkg::dmc_op_e operation_select_field;
	dmc_pkg::dmc_op_e new_op;
	logic [1:0] new_enable;
	logic [1:0] arm;
	logic cal_req;
	logic [1:0] flag_clr;
	logic [1:0] done_flag;
	logic [1:0] err_flag;
	logic [1:0] pending;
	logic [1:0] done_evt;
	logic op_finish;
	logic cal_done;
	logic [dmc_pkg::CFG_W-1:0] config_reg;
	logic [dmc_pkg::IRQ_W-1:0] irq_mask;
	logic [dmc_pkg::IRQ_W-1:0] irq_status;
	logic [dmc_pkg::IRQ_W-1:0] irq_events;
	logic [7:0] mode_view;
	logic [7:0] status_view;

	// Bus slave: one wait state, read data captured in the first cycle.
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && !ack;
	assign wr_fire = avs_write && ack;
	assign lane0 = avs_byteenable[0];
	assign mode_wr = wr_fire && lane0 && (avs_address == dmc_pkg::OFS_MODE);
	assign status_wr = wr_fire && lane0 && (avs_address == dmc_pkg::OFS_STATUS);
	assign irq_status_wr = wr_fire && lane0 && (avs_address == dmc_pkg::OFS_IRQ_STATUS);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ack <= 1'b0;
		end else begin
			ack <= req && !ack;
		end
	end

	// Reserved mode bits are not stored and read back as zero.
	assign mode_view = {2'h0, enable[0], enable[1], 1'b0, operation_select_field};
	assign status_view = {3'h0, err_flag[1], err_flag[0], cal_done, done_flag[1], done_flag[0]};

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !ack) begin
			case (avs_address)
				dmc_pkg::OFS_MODE: avs_readdata <= {24'h000000, mode_view};
				dmc_pkg::OFS_STATUS: avs_readdata <= {24'h000000, status_view};
				dmc_pkg::OFS_IRQ_STATUS: avs_readdata <= {29'h00000000, irq_status};
				dmc_pkg::OFS_IRQ_MASK: avs_readdata <= {29'h00000000, irq_mask};
				dmc_pkg::OFS_CONFIG: avs_readdata <= {26'h0000000, config_reg};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// Decode of a mode control write.
	assign new_op = dmc_pkg::dmc_op_e'(avs_writedata[dmc_pkg::FIELD_LSB +: dmc_pkg::FIELD_W]);
	assign new_enable = {avs_writedata[dmc_pkg::AUX_EN_BIT], avs_writedata[dmc_pkg::PRI_EN_BIT]};
	assign cal_req = mode_wr && dmc_pkg::op_is_cal(new_op);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			arm[i] = mode_wr && new_enable[i] && dmc_pkg::op_is_one_shot(new_op);
			// Starting a new one-shot also clears the old result flag.
			flag_clr[i] = (status_wr && avs_writedata[i]) || cal_req || arm[i];
		end
	end

	// A one-shot is over once no enabled converter still owes a result.
	// A fresh write in the same cycle wins, since it is the newer request.
	assign op_finish = dmc_pkg::op_is_one_shot(operation_select_field) && (pending == 2'h0)
		&& !mode_wr;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			enable <= dmc_pkg::ENABLE_RESET;
			operation_select_field <= dmc_pkg::FIELD_RESET;
		end else if (mode_wr) begin
			enable <= new_enable;
			operation_select_field <= new_op;
		end else if (op_finish) begin
			operation_select_field <= dmc_pkg::OP_POWER_DOWN;
		end
	end

	dmc_sticky_flag u_cal_done (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.set(op_finish && dmc_pkg::op_is_cal(operation_select_field) && (enable != 2'h0)),
		.clear(mode_wr),
		.flag(cal_done)
	);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			config_reg <= dmc_pkg::CONFIG_RESET;
			irq_mask <= dmc_pkg::MASK_RESET;
		end else if (wr_fire && lane0) begin
			if (avs_address == dmc_pkg::OFS_CONFIG) begin
				config_reg <= avs_writedata[dmc_pkg::CFG_W-1:0];
			end
			if (avs_address == dmc_pkg::OFS_IRQ_MASK) begin
				irq_mask <= avs_writedata[dmc_pkg::IRQ_W-1:0];
			end
		end
	end

	assign primary_reference_select = config_reg[dmc_pkg::CFG_PRI_REF];
	assign auxiliary_reference_select = config_reg[dmc_pkg::CFG_AUX_REF];
	assign primary_channel_select = config_reg[dmc_pkg::CFG_PRI_CH_LSB +: 2];
	assign auxiliary_channel_select = config_reg[dmc_pkg::CFG_AUX_CH_LSB +: 2];

	generate
		for (genvar g = 0; g < 2; g++) begin : g_conv
			dmc_conv_ctrl u_conv (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.enable(enable[g]),
				.op(operation_select_field),
				.field_write(mode_wr),
				.arm(arm[g]),
				.flag_clear(flag_clr[g]),
				.done_in(conv_done[g]),
				.err_in(conv_err[g]),
				.run(conv_run[g]),
				.conv_op(conv_op[g]),
				.conv_reset(conv_reset[g]),
				.idle_hold(conv_idle_hold[g]),
				.short_inputs(conv_short_inputs[g]),
				.ref_apply(conv_ref_apply[g]),
				.result_we(conv_result_we[g]),
				.coef_we(conv_coef_we[g]),
				.done_flag(done_flag[g]),
				.err_flag(err_flag[g]),
				.pending(pending[g]),
				.done_evt(done_evt[g])
			);
		end
		for (genvar g = 0; g < dmc_pkg::IRQ_W; g++) begin : g_irq
			dmc_sticky_flag u_irq (
				.ref_clk(ref_clk),
				.resetn(resetn),
				.set(irq_events[g]),
				.clear(irq_status_wr && avs_writedata[g]),
				.flag(irq_status[g])
			);
		end
	endgenerate

	assign irq_events = {op_finish, done_evt[1], done_evt[0]};

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	a_reserved_read_zero: assert property (
		(avs_read && !avs_waitrequest && avs_address == dmc_pkg::OFS_MODE)
		|-> (avs_readdata[7:6] == 2'h0) && !avs_readdata[3])
		else $error("Reserved mode bits read nonzero.");

	a_primary_enable_run: assert property (
		(enable[0] && operation_select_field != dmc_pkg::OP_POWER_DOWN)
		|=> conv_run[0] && (conv_op[0] == $past(operation_select_field)))
		else $error("Enabled primary converter not running selected operation.");

	a_primary_disable_down: assert property (
		!enable[0] |=> !conv_run[0] && (conv_op[0] == dmc_pkg::OP_POWER_DOWN))
		else $error("Disabled primary converter not powered down.");

	a_aux_enable_run: assert property (
		(enable[1] && operation_select_field != dmc_pkg::OP_POWER_DOWN)
		|=> conv_run[1] && (conv_op[1] == $past(operation_select_field)))
		else $error("Enabled auxiliary converter not running selected operation.");

	a_aux_disable_down: assert property (
		!enable[1] |=> !conv_run[1] && (conv_op[1] == dmc_pkg::OP_POWER_DOWN))
		else $error("Disabled auxiliary converter not powered down.");

	a_idle_holds_reset: assert property (
		(enable[0] && operation_select_field == dmc_pkg::OP_IDLE) |=> conv_idle_hold[0])
		else $error("Idle operation does not hold primary converter in reset.");

	a_single_returns_down: assert property (
		op_finish |=> (operation_select_field == dmc_pkg::OP_POWER_DOWN))
		else $error("Finished one-shot did not return field to power-down.");

	a_short_on_zero_cal: assert property (
		(enable[1] && operation_select_field == dmc_pkg::OP_INT_ZERO) |=> conv_short_inputs[1])
		else $error("Internal zero-scale calibration without shorted inputs.");

	a_write_resets_both: assert property (
		mode_wr |=> (conv_reset == 2'h3) ##1 (conv_reset == 2'h0 || $past(mode_wr)))
		else $error("Mode field write did not reset both converters for one cycle.");

	a_cal_clears_flags: assert property (
		(cal_req && done_evt == 2'h0) |=> (done_flag == 2'h0))
		else $error("Calibration request did not clear both done flags.");

	a_flag_holds: assert property (
		(done_flag[0] && !flag_clr[0]) |=> done_flag[0] && !conv_result_we[0])
		else $error("Primary done flag lost without a clear.");

	a_disabled_ignores: assert property (
		(!enable[1] && !enable[0]) |=> (conv_run == 2'h0) && (conv_coef_we == 2'h0))
		else $error("Disabled converters acted on the mode field.");

	a_field_reset_down: assert property (
		!$past(resetn) |-> (operation_select_field == dmc_pkg::OP_POWER_DOWN) && (enable == 2'h0))
		else $error("Mode field not at power-down after reset.");

	a_single_one_result: assert property (
		(done_evt[0] && !arm[0]) |=> !pending[0] && done_flag[0])
		else $error("Primary converter still owes a result after its one conversion.");

	a_continuous_stays: assert property (
		(operation_select_field == dmc_pkg::OP_CONTINUOUS && !mode_wr)
		|=> (operation_select_field == dmc_pkg::OP_CONTINUOUS))
		else $error("Continuous conversion left without a mode write.");

	a_full_cal_ref: assert property (
		(enable[0] && operation_select_field == dmc_pkg::OP_INT_FULL) |=> conv_ref_apply[0])
		else $error("Internal full-scale calibration without the reference applied.");

endmodule

//--- dmc_conv_model.sv
// Behavioural pair of converters facing the mode control block.
// Assumes the control block drives run and reset on ref_clk; latency comes from the bench.
module dmc_conv_model (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// From the control block.
	input wire logic [1:0] conv_run,
	input wire logic [1:0] conv_reset,
	input wire logic [1:0] conv_idle_hold,
	// From the bench.
	input wire logic [7:0] lat,
	input wire logic [1:0] err_req,
	// Completion.
	output logic [1:0] conv_done,
	output logic [1:0] conv_err
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt [2];
	always @(posedge ref_clk) begin
		for (int i = 0; i < 2; i++) begin
			conv_done[i] <= 1'b0;
			// The error line only means something with done, so it toggles otherwise.
			conv_err[i] <= ~conv_err[i];
			if (!resetn) begin
				cnt[i] <= 0;
				conv_err[i] <= 1'b0;
			end else if (conv_reset[i] || !conv_run[i] || conv_idle_hold[i]) begin
				cnt[i] <= 0;
			end else if (cnt[i] == lat) begin
				// System inputs are taken to be applied before any calibration starts.
				conv_done[i] <= 1'b1;
				conv_err[i] <= err_req[i];
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule

//--- tb_dual_adc_mode_control.sv
// Self-checking bench for the dual converter mode control block.
// Assumes one 100 MHz clock and the converter model on the far side.
module tb_dual_adc_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, irq, pref, aref;
	logic [1:0] conv_run, conv_reset, idle, short, refa, res_we, coef_we, pch, ach;
	logic [1:0][2:0] conv_op;
	logic [1:0] conv_done, conv_err;
	logic [7:0] lat = 8'h0A;
	logic [1:0] err_req = 2'h0;
	int n_mismatch = 0;
	int checks_done = 0;
	int n_rst = 0;
	int n_coef [2];
	dmc_top dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .conv_run(conv_run), .conv_op(conv_op),
		.conv_reset(conv_reset), .conv_idle_hold(idle), .conv_short_inputs(short),
		.conv_ref_apply(refa), .conv_result_we(res_we), .conv_coef_we(coef_we),
		.primary_reference_select(pref), .auxiliary_reference_select(aref),
		.primary_channel_select(pch), .auxiliary_channel_select(ach),
		.conv_done(conv_done), .conv_err(conv_err));
	dmc_conv_model conv (.ref_clk(ref_clk), .resetn(resetn), .conv_run(conv_run),
		.conv_reset(conv_reset), .conv_idle_hold(idle), .lat(lat), .err_req(err_req),
		.conv_done(conv_done),
		.conv_err(conv_err));
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (conv_reset === 2'h3) begin
			n_rst++;
		end
		for (int i = 0; i < 2; i++) begin
			if (coef_we[i] === 1'b1) begin
				n_coef[i]++;
			end
		end
	end
	task automatic tally_and_finish();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// The request stands until waitrequest is seen low at a rising edge; data is taken there.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int g;
		g = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
			g++;
		end while (avs_waitrequest !== 1'b0 && g < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_mismatch++;
			$display("FAIL %0t bus request at %h never answered", $time, a);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, q);
	endtask
	task automatic chk_reg(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		checks_done++;
		if (q !== e) begin
			n_mismatch++;
			$display("FAIL %0t register %h read %h expected %h", $time, a, q, e);
		end
	endtask
	task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %0t output %h expected %h", $time, g, e);
		end
	endtask
	initial begin
		#500000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		logic [2:0] op, m;
		logic [1:0] en;
		logic [6:0] e;
		logic [31:0] q;
		int k;
		k = $urandom(73);
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		cyc(1);
		chk_pin({irq, conv_run, conv_op, res_we}, 32'h3);
		for (k = 0; k < 5; k++) begin
			chk_reg(5'(k * 4), 32'h0);
		end
		wr(5'h14, 8'hFF);
		chk_reg(5'h14, 32'h0);
		wr(dmc_pkg::OFS_MODE, 8'hC9);
		chk_reg(dmc_pkg::OFS_MODE, 32'h1);
		chk_pin(conv_run, 32'h0);
		avs_byteenable <= 4'hE;
		wr(dmc_pkg::OFS_MODE, 8'h31);
		avs_byteenable <= 4'hF;
		chk_reg(dmc_pkg::OFS_MODE, 32'h1);
		k = $urandom;
		wr(dmc_pkg::OFS_CONFIG, {2'h0, k[5:0]});
		cyc(1);
		chk_pin({ach, pch, aref, pref}, k[5:0]);
		for (int o = 1; o < 8; o++) begin
			op = o[2:0];
			en = (o == 7) ? 2'h3 : 2'($urandom_range(1, 3));
			m = 3'($urandom);
			lat <= 8'($urandom_range(10, 30));
			err_req <= 2'($urandom);
			wr(dmc_pkg::OFS_IRQ_MASK, {5'h0, m});
			n_rst = 0;
			n_coef = '{0, 0};
			wr(dmc_pkg::OFS_MODE, {2'h0, en[0], en[1], 1'b0, op});
			chk_reg(dmc_pkg::OFS_STATUS, 32'h0);
			cyc(1);
			chk_pin(n_rst, 32'h1);
			for (int i = 0; i < 2; i++) begin
				e = en[i] ? {1'b1, op, op == 3'h1, op == 3'h4, op == 3'h5} : 7'h0;
				chk_pin({conv_run[i], conv_op[i], idle[i], short[i], refa[i]}, e);
			end
			if (op == 3'h3) begin
				repeat (3 * lat) @(posedge ref_clk);
				chk_reg(dmc_pkg::OFS_MODE, {26'h0, en[0], en[1], 4'h3});
				chk_reg(dmc_pkg::OFS_STATUS, {27'h0, en & err_req, 1'b0, en});
				chk_pin(res_we, {30'h0, ~en});
				wr(dmc_pkg::OFS_IRQ_STATUS, 8'h07);
			end else if (op == 3'h1) begin
				// An idle converter is held in reset, so no result may arrive.
				repeat (3 * lat) @(posedge ref_clk);
				chk_reg(dmc_pkg::OFS_STATUS, 32'h0);
			end else begin
				k = 0;
				do begin
					bus(1'b0, dmc_pkg::OFS_MODE, 32'h0, q);
					k++;
				end while (q[2:0] !== 3'h0 && k < 40);
				chk_reg(dmc_pkg::OFS_MODE, {26'h0, en[0], en[1], 4'h0});
				chk_reg(dmc_pkg::OFS_STATUS, {27'h0, en & err_req, op[2], en});
				chk_reg(dmc_pkg::OFS_IRQ_STATUS, {29'h0, 1'b1, en});
				chk_pin({irq, conv_run, res_we}, {|({1'b1, en} & m), 2'h0, ~en});
				e = {3'h0, op[2] & en[1] & ~err_req[1], 1'b0, op[2] & en[0] & ~err_req[0]};
				chk_pin({n_coef[1][1:0], n_coef[0][1:0]}, e);
				wr(dmc_pkg::OFS_STATUS, 8'h03);
				wr(dmc_pkg::OFS_IRQ_STATUS, 8'h07);
				cyc(2);
				chk_pin({irq, res_we}, 32'h3);
			end
		end
		wr(dmc_pkg::OFS_MODE, 8'h33);
		wr(dmc_pkg::OFS_MODE, 8'h13);
		cyc(2);
		chk_pin(conv_run, 32'h2);
		wr(dmc_pkg::OFS_MODE, 8'h23);
		cyc(2);
		chk_pin(conv_run, 32'h1);
		wr(dmc_pkg::OFS_MODE, 8'h20);
		cyc(2);
		chk_pin(conv_run, 32'h0);
		tally_and_finish();
	end
endmodule
